// ===== core/tcc_pkg.sv
// Functional notes
// [RULE1] Every capture event overwrites the capture value, read or not.
// [RULE2] Software reads the capture value early in its capture handler.
// [RULE3] Duty-cycle measurement flips capture edge sense after each capture.
// [RULE4] After an edge change software clears the capture flag by writing one.
// [RULE5] With retrigger enabled the capture flag is ORed into the ceiling signal.
// [RULE6] Full-width compare; match flag sets one timer tick after equality.
// [RULE7] Enabled match flag interrupts; cleared by acknowledge or writing one.
// [RULE8] Compare channel A can serve as the counter ceiling.
// [RULE9] PWM modes double buffer compare values, loaded at ceiling or floor; the code loads them at the ceiling only.
// [RULE10] Compare writes go to buffer when buffered, else the active register.
// [RULE11] Compare reads return both bytes directly, bypassing the shared latch.
// [RULE12] High byte goes to the shared latch; low write loads all 16 bits.
// [RULE13] Force strobe in non-PWM modes acts on output only, no flag or counter.
// [RULE14] A counter write suppresses matches in the next timer tick.
// [RULE15] Software must not write counter to ceiling or zero in unsafe cases.
// [RULE16] Compare output state survives waveform mode changes.
// [RULE17] Output action bits are unbuffered; apply at next match or force.
// [RULE18] Reset clears the compare output state.
// [RULE19] Nonzero action select makes compare output override port value.
// [RULE20] Output action select has no effect on input capture.
// [RULE21] Action zero leaves compare output unchanged on match.
// [RULE22] Non-PWM action one toggles compare output on match.
// [RULE23] Modes 4 and 12 are clear-on-match with channel A or capture ceiling.
// [RULE24] Modes 5, 6, 7, 14, 15 are single-slope fast PWM.
// [RULE25] Non-PWM action two clears, action three sets compare output.
`default_nettype none
package tcc_pkg;
	localparam int CW = 16;
	// *****************************************************************
	// Register offsets on the APB (byte addresses)
	// *****************************************************************
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_FLAGS  = 8'h04;
	localparam logic [7:0] OFS_CNT_L  = 8'h08;
	localparam logic [7:0] OFS_CNT_H  = 8'h0c;
	localparam logic [7:0] OFS_CAP_L  = 8'h10;
	localparam logic [7:0] OFS_CAP_H  = 8'h14;
	localparam logic [7:0] OFS_CMPA_L = 8'h18;
	localparam logic [7:0] OFS_CMPA_H = 8'h1c;
	localparam logic [7:0] OFS_CMPB_L = 8'h20;
	localparam logic [7:0] OFS_CMPB_H = 8'h24;
	localparam logic [7:0] OFS_FORCE  = 8'h28;
	// *****************************************************************
	// Control register fields
	// *****************************************************************
	localparam int CTRL_WGM_LSB = 0;  // waveform_select [3:0]
	localparam int CTRL_OASA    = 4;  // output_action_select A [5:4]
	localparam int CTRL_OASB    = 6;  // output_action_select B [7:6]
	localparam int CTRL_IEA     = 8;  // match_irq_enable A
	localparam int CTRL_IEB     = 9;  // match_irq_enable B
	localparam int CTRL_IEC     = 10; // capture irq enable
	localparam int CTRL_RTG     = 11; // retrigger enable
	localparam int CTRL_DIRA    = 12; // output_pin_direction_bit A
	localparam int CTRL_DIRB    = 13; // output_pin_direction_bit B
	localparam int FLG_MA       = 0;
	localparam int FLG_MB       = 1;
	localparam int FLG_CAP      = 2;
	localparam int FLG_CEIL     = 3;
	localparam logic [13:0] CTRL_RESET = 14'h0000;
	// Waveform select codes
	localparam logic [3:0] WGM_NORMAL  = 4'h0;
	localparam logic [3:0] WGM_CTC_A   = 4'h4;
	localparam logic [3:0] WGM_FP8     = 4'h5;
	localparam logic [3:0] WGM_FP9     = 4'h6;
	localparam logic [3:0] WGM_FP10    = 4'h7;
	localparam logic [3:0] WGM_CTC_CAP = 4'hc;
	localparam logic [3:0] WGM_RSVD    = 4'hd;
	localparam logic [3:0] WGM_FP_CAP  = 4'he;
	localparam logic [3:0] WGM_FP_A    = 4'hf;
	localparam logic [15:0] TOP_8  = 16'h00ff;
	localparam logic [15:0] TOP_9  = 16'h01ff;
	localparam logic [15:0] TOP_10 = 16'h03ff;
	localparam logic [15:0] TOP_MAX = 16'hffff;
	localparam logic [15:0] FLOOR  = 16'h0000;
	// Output action codes
	localparam logic [1:0] OA_NONE = 2'h0;
	localparam logic [1:0] OA_TOG  = 2'h1;
	localparam logic [1:0] OA_CLR  = 2'h2;
	localparam logic [1:0] OA_SET  = 2'h3;
	// Per-channel compare state
	typedef struct packed {
		logic [15:0] active;
		logic [15:0] buffer;
		logic        out;
		logic        flag;
	} tcc_chan_type;
	// Timer-side status that travels to the top
	typedef struct packed {
		logic        ceil;
		logic        floor;
		logic [15:0] count;
	} tcc_cnt_type;
endpackage
`default_nettype wire

// ===== core/tcc_timer.sv
// Chosen here: the APB slave port and the address map.
`default_nettype none
module tcc_timer (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        CE,
	input  wire logic        TICK,
	input  wire logic        CAPTURE_PIN,
	input  wire logic        CAPTURE_EDGE,
	input  wire logic [1:0]  PORT_VALUE,
	input  wire logic        IRQ_ACK_A,
	input  wire logic        IRQ_ACK_B,
	input  wire logic        IRQ_ACK_CAP,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic      [1:0]  PIN_OUT,
	output logic      [1:0]  PIN_OE_N,
	output logic             IRQ_MATCH_A,
	output logic             IRQ_MATCH_B,
	output logic             IRQ_CAPTURE
);
	// *****************************************************************
	// State
	// *****************************************************************
	typedef struct packed {
		logic               pin_sync0;
		logic               pin_sync1;
		logic               pin_last;
		logic [13:0]        ctrl;
		logic [15:0]        count;
		logic [7:0]         temp;
		logic [15:0]        capture_value_reg;
		logic               capture_event_flag;
		logic               ceil_flag;
		logic               block;
		tcc_pkg::tcc_chan_type [1:0] ch;
	} tcc_state_type;

	tcc_state_type st;
	tcc_state_type next_st;

	logic        wr;
	logic        rd;
	logic [3:0]  wgm;
	logic        is_pwm;
	logic        clear_on_match_mode;
	logic [15:0] ceiling;
	logic        at_ceil;
	logic        at_floor;
	logic        top_hit;
	logic        cap_evt;
	logic        pin_now;
	logic [1:0]  oas [2];
	logic [1:0]  eq;

	assign wr     = PSEL && PENABLE && PWRITE;
	assign rd     = PSEL && !PWRITE;
	assign wgm    = st.ctrl[tcc_pkg::CTRL_WGM_LSB +: 4];
	assign oas[0] = st.ctrl[tcc_pkg::CTRL_OASA +: 2];
	assign oas[1] = st.ctrl[tcc_pkg::CTRL_OASB +: 2];
	assign PREADY  = 1'b1;
	assign PSLVERR = 1'b0;

	// Mode decode: only single-slope modes are modelled in the counter
	always_comb begin
		clear_on_match_mode    = (wgm == tcc_pkg::WGM_CTC_A) || (wgm == tcc_pkg::WGM_CTC_CAP); // RULE23
		is_pwm = !(wgm == tcc_pkg::WGM_NORMAL || clear_on_match_mode); // RULE9
		case (wgm)
			tcc_pkg::WGM_CTC_A,
			tcc_pkg::WGM_FP_A:   ceiling = st.ch[0].active; // RULE8
			tcc_pkg::WGM_CTC_CAP,
			tcc_pkg::WGM_FP_CAP: ceiling = st.capture_value_reg; // RULE23
			tcc_pkg::WGM_FP8:    ceiling = tcc_pkg::TOP_8; // RULE24
			tcc_pkg::WGM_FP9:    ceiling = tcc_pkg::TOP_9;
			tcc_pkg::WGM_FP10:   ceiling = tcc_pkg::TOP_10;
			default:             ceiling = tcc_pkg::TOP_MAX;
		endcase
	end

	// Capture edge after the synchroniser; edge sense set by the CAPTURE_EDGE input
	assign pin_now  = st.pin_sync1;
	assign cap_evt  = (pin_now != st.pin_last) && (pin_now == CAPTURE_EDGE);
	assign at_ceil  = (st.count == ceiling);
	assign at_floor = (st.count == tcc_pkg::FLOOR);
	// Retrigger makes the capture flag look like the ceiling
	assign top_hit  = at_ceil || (st.ctrl[tcc_pkg::CTRL_RTG] && st.capture_event_flag); // RULE5

	generate
		for (genvar c = 0; c < 2; c++) begin : g_eq
			// Full 16-bit equality, valid on a timer tick only
			assign eq[c] = (st.count == st.ch[c].active); // RULE6
		end
	endgenerate

	// *****************************************************************
	// Next-state logic
	// *****************************************************************
	always_comb begin
		logic [15:0] wval;
		logic        match;
		logic        force_hit;
		wval = 16'h0000;
		match = 1'b0;
		force_hit = 1'b0;
		next_st = st;
		next_st.pin_sync0 = CAPTURE_PIN;
		next_st.pin_sync1 = st.pin_sync0;
		next_st.pin_last  = pin_now;
		wval = {st.temp, PWDATA[7:0]}; // RULE12
		// Counter runs on ticks; a write wins over counting
		if (TICK) begin
			next_st.block = 1'b0;
			if (top_hit) begin
				next_st.count = tcc_pkg::FLOOR;
				next_st.ceil_flag = 1'b1;
			end else begin
				next_st.count = st.count + 16'h0001;
			end
		end
		// Capture overwrites unconditionally; output action plays no part
		if (cap_evt) begin
			next_st.capture_value_reg  = st.count; // RULE1 RULE20
			next_st.capture_event_flag = 1'b1;
		end
		for (int c = 0; c < 2; c++) begin
			match = TICK && eq[c] && !st.block; // RULE14
			force_hit = wr && (PADDR == tcc_pkg::OFS_FORCE) && PWDATA[c] && !is_pwm;
			// Buffered value moves in at ceiling (fast PWM) on a tick
			if (is_pwm && TICK && at_ceil) begin
				next_st.ch[c].active = st.ch[c].buffer; // RULE9
			end
			if (match || force_hit) begin // RULE13 RULE17
				if (is_pwm) begin
					if (oas[c] == tcc_pkg::OA_CLR) next_st.ch[c].out = 1'b0;
					if (oas[c] == tcc_pkg::OA_SET) next_st.ch[c].out = 1'b1;
				end else begin
					case (oas[c])
						tcc_pkg::OA_NONE: next_st.ch[c].out = st.ch[c].out; // RULE21
						tcc_pkg::OA_TOG:  next_st.ch[c].out = !st.ch[c].out; // RULE22
						tcc_pkg::OA_CLR:  next_st.ch[c].out = 1'b0; // RULE25
						tcc_pkg::OA_SET:  next_st.ch[c].out = 1'b1; // RULE25
						default:          next_st.ch[c].out = st.ch[c].out;
					endcase
				end
			end else if (is_pwm && TICK && at_ceil) begin
				// Fast PWM restores the idle level at the ceiling
				if (oas[c] == tcc_pkg::OA_CLR) next_st.ch[c].out = 1'b1;
				if (oas[c] == tcc_pkg::OA_SET) next_st.ch[c].out = 1'b0;
			end
			// Flag clear by ack or write-one; a fresh match wins
			if (c == 0 ? IRQ_ACK_A : IRQ_ACK_B) next_st.ch[c].flag = 1'b0; // RULE7
			if (wr && PADDR == tcc_pkg::OFS_FLAGS && PWDATA[c]) next_st.ch[c].flag = 1'b0;
			if (match) next_st.ch[c].flag = 1'b1; // RULE6
		end
		if (IRQ_ACK_CAP || (wr && PADDR == tcc_pkg::OFS_FLAGS && PWDATA[tcc_pkg::FLG_CAP])) begin
			next_st.capture_event_flag = cap_evt;
		end
		if (wr && PADDR == tcc_pkg::OFS_FLAGS && PWDATA[tcc_pkg::FLG_CEIL]) begin
			next_st.ceil_flag = TICK && top_hit;
		end
		// Register writes; mode change leaves the output states alone
		if (wr) begin
			case (PADDR)
				tcc_pkg::OFS_CTRL: next_st.ctrl = PWDATA[13:0]; // RULE16 RULE17
				tcc_pkg::OFS_CNT_H,
				tcc_pkg::OFS_CAP_H,
				tcc_pkg::OFS_CMPA_H,
				tcc_pkg::OFS_CMPB_H: next_st.temp = PWDATA[7:0]; // RULE12
				tcc_pkg::OFS_CNT_L: begin
					next_st.count = wval;
					next_st.block = 1'b1; // RULE14
				end
				tcc_pkg::OFS_CAP_L: next_st.capture_value_reg = wval;
				tcc_pkg::OFS_CMPA_L: begin
					if (is_pwm) next_st.ch[0].buffer = wval; // RULE10
					else next_st.ch[0].active = wval;
				end
				tcc_pkg::OFS_CMPB_L: begin
					if (is_pwm) next_st.ch[1].buffer = wval; // RULE10
					else next_st.ch[1].active = wval;
				end
				default: next_st.temp = st.temp;
			endcase
		end
		// Low-byte reads of timer-updated values latch their high byte
		if (rd && !PENABLE && PADDR == tcc_pkg::OFS_CNT_L) next_st.temp = st.count[15:8];
		if (rd && !PENABLE && PADDR == tcc_pkg::OFS_CAP_L) begin
			next_st.temp = st.capture_value_reg[15:8];
		end
		if (!CE) next_st = st;
		if (!RST_N) begin
			next_st = '0;
			next_st.ctrl = tcc_pkg::CTRL_RESET;
			next_st.ch[0].out = 1'b0; // RULE18
			next_st.ch[1].out = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		st <= next_st;
	end

	// *****************************************************************
	// Read mux; compare values bypass the shared latch
	// *****************************************************************
	always_comb begin
		PRDATA = 32'h0000_0000;
		case (PADDR)
			tcc_pkg::OFS_CTRL:   PRDATA[13:0] = st.ctrl;
			tcc_pkg::OFS_FLAGS:  PRDATA[3:0] = {st.ceil_flag, st.capture_event_flag,
			                                    st.ch[1].flag, st.ch[0].flag};
			tcc_pkg::OFS_CNT_L:  PRDATA[7:0] = st.count[7:0];
			tcc_pkg::OFS_CNT_H,
			tcc_pkg::OFS_CAP_H:  PRDATA[7:0] = st.temp;
			tcc_pkg::OFS_CAP_L:  PRDATA[7:0] = st.capture_value_reg[7:0];
			tcc_pkg::OFS_CMPA_L: PRDATA[7:0] = is_pwm ? st.ch[0].buffer[7:0] : st.ch[0].active[7:0];
			tcc_pkg::OFS_CMPA_H: PRDATA[7:0] = is_pwm ? st.ch[0].buffer[15:8] : st.ch[0].active[15:8]; // RULE11
			tcc_pkg::OFS_CMPB_L: PRDATA[7:0] = is_pwm ? st.ch[1].buffer[7:0] : st.ch[1].active[7:0];
			tcc_pkg::OFS_CMPB_H: PRDATA[7:0] = is_pwm ? st.ch[1].buffer[15:8] : st.ch[1].active[15:8]; // RULE11
			default:             PRDATA = 32'h0000_0000;
		endcase
	end

	// Pin override: compare output replaces port value, direction stays with software
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			PIN_OUT[c] = (oas[c] != tcc_pkg::OA_NONE) ? st.ch[c].out : PORT_VALUE[c]; // RULE19
		end
		PIN_OE_N[0] = !st.ctrl[tcc_pkg::CTRL_DIRA]; // RULE19
		PIN_OE_N[1] = !st.ctrl[tcc_pkg::CTRL_DIRB];
	end

	assign IRQ_MATCH_A = st.ch[0].flag && st.ctrl[tcc_pkg::CTRL_IEA]; // RULE7
	assign IRQ_MATCH_B = st.ch[1].flag && st.ctrl[tcc_pkg::CTRL_IEB];
	assign IRQ_CAPTURE = st.capture_event_flag && st.ctrl[tcc_pkg::CTRL_IEC];
endmodule
`default_nettype wire

// ===== test/tcc_cpu.sv
`default_nettype none
// ****************
// Processor-side APB master
// ****************
module tcc_cpu (
	input  wire logic        CLK,
	output var  logic        PSEL,
	output var  logic        PENABLE,
	output var  logic        PWRITE,
	output var  logic [7:0]  PADDR,
	output var  logic [31:0] PWDATA,
	input  wire logic [31:0] PRDATA,
	input  wire logic        PREADY
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		PSEL = 1'h0;
		PENABLE = 1'h0;
		PWRITE = 1'h0;
		PADDR = 8'hff;
		PWDATA = 32'h0;
	end
	// One transfer; held until pready is seen at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge CLK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'h1;
		@(posedge CLK);
		while (PREADY !== 1'h1) @(posedge CLK);
		q = PRDATA;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		PADDR <= ~a;   // Released lines do not keep their last value
		PWDATA <= ~d;
		@(negedge CLK);
	endtask
	// High byte first, so the low write loads the whole word at once
	task automatic wr16(input logic [7:0] al, input logic [15:0] v);
		logic [31:0] q;
		xfer(1'h1, al + 8'h04, {24'h0, v[15:8]}, q);
		xfer(1'h1, al, {24'h0, v[7:0]}, q);
	endtask
endmodule
`default_nettype wire

// ===== test/tcc_timer_chk.sv
`default_nettype none
// ****************
// Port-level checker
// ****************
module tcc_timer_chk (
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        CE,
	input wire logic        TICK,
	input wire logic        IRQ_ACK_A,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [1:0]  PORT_VALUE,
	input wire logic [1:0]  PIN_OUT,
	input wire logic [1:0]  PIN_OE_N,
	input wire logic        IRQ_MATCH_A
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        wr;
	logic        fa;
	logic        npwm;
	logic [13:0] sh;
	// Shadow of the control word, updated on the same edge as the design
	always_ff @(posedge CLK) begin
		if (!RST_N)
			sh <= 14'h0;
		else if (wr && PADDR == tcc_pkg::OFS_CTRL)
			sh <= PWDATA[13:0];
	end
	assign wr = PSEL && PENABLE && PWRITE && CE;
	// Force on channel A with no tick, so no real match can interfere
	assign fa = wr && PADDR == tcc_pkg::OFS_FORCE && PWDATA[0] && !TICK;
	assign npwm = sh[3:0] == tcc_pkg::WGM_NORMAL || sh[3:0] == tcc_pkg::WGM_CTC_A
		|| sh[3:0] == tcc_pkg::WGM_CTC_CAP;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	AST_OE_DIR: assert property (wr && PADDR == tcc_pkg::OFS_CTRL
		|=> PIN_OE_N == ~$past(PWDATA[13:12])) else $error("pin enable off direction bits");
	AST_PORT_PASS: assert property (sh[5:4] == tcc_pkg::OA_NONE
		|-> PIN_OUT[0] == PORT_VALUE[0]) else $error("port value not passed");
	AST_FORCE_SETCLR: assert property (fa && npwm && sh[5]
		|=> PIN_OUT[0] == $past(sh[4])) else $error("force set or clear wrong");
	AST_FORCE_TOG: assert property (fa && npwm && sh[5:4] == tcc_pkg::OA_TOG
		|=> PIN_OUT[0] != $past(PIN_OUT[0])) else $error("force toggle missing");
	AST_FORCE_NOFLAG: assert property (fa && !IRQ_MATCH_A
		|=> !IRQ_MATCH_A) else $error("force raised match flag");
	AST_FLAG_ON_TICK: assert property ($rose(IRQ_MATCH_A) && $past(sh[8])
		|-> $past(TICK)) else $error("match flag set off a tick");
	AST_ACK_CLR: assert property (IRQ_ACK_A && CE && !TICK
		|=> !IRQ_MATCH_A) else $error("acknowledge did not clear");
	AST_W1C: assert property (wr && PADDR == tcc_pkg::OFS_FLAGS && PWDATA[0] && !TICK
		|=> !IRQ_MATCH_A) else $error("write one did not clear");
	AST_RESET_OUT: assert property (disable iff (1'h0) !RST_N && CE
		|=> PIN_OE_N == 2'h3 && !IRQ_MATCH_A) else $error("reset state wrong");
	cover property (fa && npwm);
	cover property ($rose(IRQ_MATCH_A));
	cover property (IRQ_ACK_A && IRQ_MATCH_A);
endmodule
bind tcc_timer tcc_timer_chk u_tcc_timer_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE), .TICK(TICK),
	.IRQ_ACK_A(IRQ_ACK_A), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PWDATA(PWDATA), .PORT_VALUE(PORT_VALUE), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
	.IRQ_MATCH_A(IRQ_MATCH_A));
`default_nettype wire

// ===== test/tb.sv
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
// ****************
// Testbench top
// ****************
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, tick, cap_pin, cap_edge, ack_a, ack_b, ce;
	logic [1:0]  port_value;
	logic        psel, penable, pwrite, pready, pslverr, irq_a, irq_b, irq_cap;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0]  pin_out, pin_oe_n;
	logic [7:0]  b;
	int          num_errors, n_tests;
	tcc_timer u_tcc_timer (.CLK(clk), .RST_N(rst_n), .CE(ce), .TICK(tick),
		.CAPTURE_PIN(cap_pin), .CAPTURE_EDGE(cap_edge), .PORT_VALUE(port_value),
		.IRQ_ACK_A(ack_a), .IRQ_ACK_B(ack_b), .IRQ_ACK_CAP(1'h0), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
		.IRQ_MATCH_A(irq_a), .IRQ_MATCH_B(irq_b), .IRQ_CAPTURE(irq_cap));
	tcc_cpu u_tcc_cpu (.CLK(clk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready));
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// Bus helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_tcc_cpu.xfer(1'h1, a, d, q);
	endtask
	task automatic rd8(input logic [7:0] a, output logic [7:0] v);
		logic [31:0] q;
		u_tcc_cpu.xfer(1'h0, a, 32'h0, q);
		v = q[7:0];
	endtask
	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'h1;
			@(posedge clk);
			tick <= 1'h0;
		end
		@(negedge clk);
	endtask
	// Output state, forcing and pin override
	task automatic t_out();
		`CHK(pin_out, 2'h2)
		`CHK(pin_oe_n, 2'h3)
		wr(tcc_pkg::OFS_CTRL, 32'h1010);
		`CHK(pin_out[0], 1'h0)
		`CHK(pin_oe_n, 2'h2)
		wr(tcc_pkg::OFS_FORCE, 32'h1);
		`CHK(pin_out[0], 1'h1)
		rd8(tcc_pkg::OFS_FLAGS, b);
		`CHK(b[0], 1'h0)
		wr(tcc_pkg::OFS_CTRL, 32'h1020);
		wr(tcc_pkg::OFS_FORCE, 32'h1);
		`CHK(pin_out[0], 1'h0)
		wr(tcc_pkg::OFS_CTRL, 32'h1030);
		wr(tcc_pkg::OFS_FORCE, 32'h1);
		`CHK(pin_out[0], 1'h1)
		wr(tcc_pkg::OFS_CTRL, 32'h1000);
		`CHK(pin_out[0], 1'h0)
		wr(tcc_pkg::OFS_FORCE, 32'h1);
		wr(tcc_pkg::OFS_CTRL, 32'h1035);
		`CHK(pin_out[0], 1'h1)
	endtask
	// Mid-run reset must bring the output state back to zero
	task automatic t_rst();
		@(posedge clk);
		rst_n <= 1'h0;
		@(posedge clk);
		rst_n <= 1'h1;
		@(negedge clk);
		`CHK(pin_oe_n, 2'h3)
		wr(tcc_pkg::OFS_CTRL, 32'h1010);
		`CHK(pin_out[0], 1'h0)
	endtask
	// Clock enable low freezes register writes
	task automatic t_ce();
		@(posedge clk);
		ce <= 1'h0;
		wr(tcc_pkg::OFS_CTRL, 32'h3000);
		@(posedge clk);
		ce <= 1'h1;
		@(negedge clk);
		`CHK(pin_oe_n, 2'h3)
	endtask
	// Compare register bytes and the shared high-byte latch
	task automatic t_cmp();
		wr(tcc_pkg::OFS_CTRL, 32'h0);
		u_tcc_cpu.wr16(tcc_pkg::OFS_CMPA_L, 16'h1234);
		rd8(tcc_pkg::OFS_CMPA_H, b);
		`CHK(b, 8'h12)
		wr(tcc_pkg::OFS_CMPB_H, 32'hab);
		rd8(tcc_pkg::OFS_CMPA_H, b);
		`CHK(b, 8'h12)
		wr(tcc_pkg::OFS_CMPA_L, 32'h56);
		rd8(tcc_pkg::OFS_CMPA_H, b);
		`CHK(b, 8'hab)
		rd8(tcc_pkg::OFS_CMPA_L, b);
		`CHK(b, 8'h56)
		`CHK(pslverr, 1'h0)
	endtask
	// Match timing, blocking after counter writes, flag clearing
	task automatic t_match();
		wr(tcc_pkg::OFS_CTRL, 32'h100);
		u_tcc_cpu.wr16(tcc_pkg::OFS_CMPA_L, 16'h0010);
		u_tcc_cpu.wr16(tcc_pkg::OFS_CNT_L, 16'h0010);
		tk(1);
		`CHK(irq_a, 1'h0)
		u_tcc_cpu.wr16(tcc_pkg::OFS_CNT_L, 16'h0020);
		u_tcc_cpu.wr16(tcc_pkg::OFS_CMPA_L, 16'h0022);
		tk(2);
		`CHK(irq_a, 1'h0)
		tk(1);
		`CHK(irq_a, 1'h1)
		@(posedge clk);
		ack_a <= 1'h1;
		@(posedge clk);
		ack_a <= 1'h0;
		@(negedge clk);
		`CHK(irq_a, 1'h0)
		u_tcc_cpu.wr16(tcc_pkg::OFS_CNT_L, 16'h0021);
		tk(2);
		`CHK(irq_a, 1'h1)
		wr(tcc_pkg::OFS_FLAGS, 32'h1);
		`CHK(irq_a, 1'h0)
	endtask
	// Buffered compare in fast PWM
	task automatic t_buf();
		u_tcc_cpu.wr16(tcc_pkg::OFS_CMPB_L, 16'h0040);
		wr(tcc_pkg::OFS_FLAGS, 32'h3);
		wr(tcc_pkg::OFS_CTRL, 32'h205);
		u_tcc_cpu.wr16(tcc_pkg::OFS_CNT_L, 16'h0010);
		u_tcc_cpu.wr16(tcc_pkg::OFS_CMPB_L, 16'h0012);
		rd8(tcc_pkg::OFS_CMPB_L, b);
		`CHK(b, 8'h12)
		tk(4);
		`CHK(irq_b, 1'h0)
		// Run through the ceiling so the buffered value becomes active
		u_tcc_cpu.wr16(tcc_pkg::OFS_CNT_L, 16'h00fe);
		tk(2);
		u_tcc_cpu.wr16(tcc_pkg::OFS_CNT_L, 16'h0011);
		tk(2);
		`CHK(irq_b, 1'h1)
		@(posedge clk);
		ack_b <= 1'h1;
		@(posedge clk);
		ack_b <= 1'h0;
		@(negedge clk);
		`CHK(irq_b, 1'h0)
	endtask
	// Capture overwrite with an output action active; read early, flip edge, clear
	task automatic t_cap();
		wr(tcc_pkg::OFS_CTRL, 32'h1c10);
		u_tcc_cpu.wr16(tcc_pkg::OFS_CNT_L, 16'h0123);
		@(posedge clk);
		cap_pin <= 1'h1;
		repeat (6) @(posedge clk);
		rd8(tcc_pkg::OFS_CAP_L, b);
		`CHK(b, 8'h23)
		rd8(tcc_pkg::OFS_CAP_H, b);
		`CHK(b, 8'h01)
		`CHK(irq_cap, 1'h1)
		// Retrigger: a standing capture flag acts as the ceiling on the next tick
		tk(1);
		rd8(tcc_pkg::OFS_CNT_L, b);
		`CHK(b, 8'h00)
		@(posedge clk);
		cap_edge <= 1'h0;
		u_tcc_cpu.wr16(tcc_pkg::OFS_CNT_L, 16'h0456);
		@(posedge clk);
		cap_pin <= 1'h0;
		repeat (6) @(posedge clk);
		wr(tcc_pkg::OFS_FLAGS, 32'h4);
		rd8(tcc_pkg::OFS_FLAGS, b);
		`CHK(b[2], 1'h0)
		`CHK(irq_cap, 1'h0)
		rd8(tcc_pkg::OFS_CAP_L, b);
		`CHK(b, 8'h56)
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog: the tests need a few hundred cycles
	initial begin
		#100000;
		num_errors++;
		close_out();
	end
	initial begin
		{rst_n, tick, cap_pin, ack_a, ack_b} = 5'h00;
		ce = 1'h1;
		cap_edge = 1'h1;
		port_value = 2'h2;
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		@(negedge clk);
		t_out();
		t_rst();
		t_cmp();
		t_ce();
		t_match();
		t_buf();
		t_cap();
		close_out();
	end
endmodule
`default_nettype wire
